// [tb/isa_io_dev.sv]
// Model of an ISA I/O device that keeps asking for back-to-back I/O cycles.
// Assumes grant is a one-cycle pulse on mclk.
`timescale 1ns/1ps
module isa_io_dev
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic go,
  input  wire logic io_cmd_grant,
  output logic      io_cmd_req,
  output logic      io_cmd_end
);
  int n;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_cmd_req <= 1'b0;
      io_cmd_end <= 1'b0;
      n <= 0;
    end
    else
    begin
      io_cmd_end <= 1'b0;
      if (n > 0)
      begin
        n <= n - 1;
        io_cmd_end <= (n == 1);
      end
      else if (io_cmd_grant)
      begin
        io_cmd_req <= 1'b0;
        n <= 3;
      end
      else
        io_cmd_req <= go;
    end
  end
endmodule

// [tb/isa_recovery_speed_control_tb_top.sv]
// Self-checking bench for the recovery, refresh and speed control block.
// Assumes the I/O device model and 16-cycle refresh base.
`timescale 1ns/1ps
`include "isa_ctrl_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module isa_recovery_speed_control_tb_top;
  logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, rerr, osc = 0, go = 0, req, cend, grant;
  logic [7:0]  ratio = 8'h03, v;
  logic        ferr_n = 1, cirq, i12 = 0, kbc = 0, i12o, rref, btn = 1, ind;
  logic        a16 = 0, rom = 0, ia16, pf;
  int          err_total, total_checks, cyc, t_end, gap, t_ref, rper, lo, hi, k;
  int          ev[2];
  initial forever #2 mclk = ~mclk;
  isa_recovery_speed_control #(.REFRESH_BASE_CYC(16)) dut (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .isa_clk_osc_sel(osc),
    .cpu_clk_ratio(ratio), .io_cmd_req(req), .io_cmd_end(cend), .io_cmd_grant(grant),
    .coproc_error_in_n(ferr_n), .coproc_irq(cirq), .irq12_in(i12), .kbc_read(kbc),
    .irq12_out(i12o), .refresh_req(rref), .speed_button_in(btn),
    .speed_indicator_out(ind), .cpu_a16(a16), .rom_ef_access(rom), .isa_a16(ia16),
    .prefetch_en(pf));
  isa_io_dev dev (.mclk(mclk), .rst_n(rst_n), .go(go), .io_cmd_grant(grant),
    .io_cmd_req(req), .io_cmd_end(cend));
  always @(posedge mclk)
  begin
    cyc++;
    if (cend) t_end = cyc;
    if (grant)
    begin
      gap = cyc - t_end;
      ev[0]++;
    end
    if (rref)
    begin
      rper = cyc - t_ref;
      t_ref = cyc;
      ev[1]++;
    end
  end
  task stop_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Upper data bits carry noise that the slave must ignore
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    logic [31:0] r;
    r = $urandom;
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {r[23:0], d};
    @(posedge mclk);
    penable <= 1;
    for (n = 0; n < 10 && pready !== 1'b1; n++) @(posedge mclk);
    if (n == 10)
    begin
      err_total++;
      stop_test();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input logic [11:0] a, input logic [7:0] e);
    apb(0, a, 8'h00);
    `CHK("rdata", {24'h0, e}, rd)
  endtask
  task wev(input int i, input int t);
    int n;
    for (n = 0; n < 3000 && ev[i] < t; n++) @(posedge mclk);
    @(posedge mclk);
    if (n == 3000)
    begin
      err_total++;
      stop_test();
    end
  endtask
  // Button changes after the write, so a rising button is the latest request
  task sp(input logic [7:0] w, input logic b, input logic f);
    apb(1, `SPEED_CTRL_ADDR, w);
    btn <= b;
    repeat (3) @(posedge mclk);
    rdc(`SPEED_CTRL_ADDR, {w[7:5], f, b, w[2:0]});
    `CHK("led", f, ind)
    `CHK("pf", w[7], pf)
  endtask
  initial
  begin
    void'($urandom(72));
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    `CHK("pf_rst", 1'b1, pf)
    rdc(`REC_CTRL_ADDR, 8'h00);
    rdc(`SPEED_CTRL_ADDR, 8'hDB);
    apb(1, 12'h000, 8'h55);
    rdc(12'h000, 8'h00);
    `CHK("slverr", 1'b1, rerr)
    repeat (4)
    begin
      v = 8'($urandom);
      apb(1, `REC_CTRL_ADDR, v);
      rdc(`REC_CTRL_ADDR, v);
    end
    go <= 1;
    for (int c = 0; c < 10; c++)
    begin
      v = (c < 8) ? {3'h0, c[3:0], 1'b1} : (c == 8) ? 8'h0E : 8'h03;
      osc <= (c == 9);
      // Divide factor varies so the programmed path is exercised, not one ratio
      ratio <= 8'(2 + $urandom % 4);
      apb(1, `REC_CTRL_ADDR, v);
      wev(0, ev[0] + 2);
      k = (c == 9) ? `OSC_ISA_DIV : int'(ratio);
      hi = v[0] ? 4 * v[3:1] * k : 0;
      lo = hi - k;
      hi = hi + k + 4;
      `CHK("gap", 1'b1, gap >= lo && gap <= hi)
    end
    go <= 0;
    osc <= 0;
    for (int s = 0; s < 4; s++)
    begin
      apb(1, `REC_CTRL_ADDR, {1'b0, s[1:0], 5'h00});
      // Third pulse: the first two may still come from reloads made before the write
      wev(1, ev[1] + 3);
      `CHK("refresh", 16 << s, rper)
    end
    ferr_n <= 0;
    for (int m = 0; m < 2; m++)
    begin
      apb(1, `REC_CTRL_ADDR, {3'h0, m[0], 4'h0});
      repeat (3) @(posedge mclk);
      `CHK("cirq", ~m[0], cirq)
    end
    ferr_n <= 1;
    apb(1, `REC_CTRL_ADDR, 8'h80);
    i12 <= 1;
    @(posedge mclk);
    i12 <= 0;
    repeat (3) @(posedge mclk);
    `CHK("irq12_held", 1'b1, i12o)
    kbc <= 1;
    @(posedge mclk);
    kbc <= 0;
    repeat (2) @(posedge mclk);
    `CHK("irq12_clr", 1'b0, i12o)
    sp(8'h44, 1, 1);
    sp(8'h44, 0, 0);
    sp(8'h40, 1, 0);
    sp(8'h42, 0, 1);
    sp(8'h45, 1, 1);
    sp(8'h45, 1, 0);
    for (int s = 0; s < 2; s++)
    begin
      apb(1, `SPEED_CTRL_ADDR, {2'b11, s[0], 5'h04});
      repeat (4)
      begin
        a16 <= 1'($urandom);
        rom <= 1'($urandom);
        repeat (3) @(posedge mclk);
        `CHK("a16", a16 ^ (rom & s[0]), ia16)
      end
      `CHK("pf_on", 1'b1, pf)
    end
    stop_test();
  end
endmodule

// [verilog/isa_clk_div.sv]
// Divider that makes the one-cycle ISA bus clock enable from mclk.
// Assumes ratio is at least 2 and may change at any time.
`timescale 1ns/1ps
module isa_clk_div
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] ratio,
  output logic            tick
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_tick;

  always_comb
  begin
    next_tick = 1'b0;
    next_cnt  = cnt + 8'h01;
    if (cnt >= ratio - 8'h01)
    begin
      next_cnt  = 8'h00;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// [verilog/isa_ctrl_defs.svh]
// Offsets, reset values and timing counts of the ISA recovery/speed registers.
// Assumes a 250 MHz mclk and a 32-bit APB with one register per word.
`ifndef ISA_CTRL_DEFS_SVH
`define ISA_CTRL_DEFS_SVH
`define REC_CTRL_INDEX    8'h2A
`define SPEED_CTRL_INDEX  8'h2B
`define REC_CTRL_ADDR     (12'h004 * {4'h0, `REC_CTRL_INDEX})
`define SPEED_CTRL_ADDR   (12'h004 * {4'h0, `SPEED_CTRL_INDEX})
`define REC_CTRL_RESET    8'h00
`define SPEED_CTRL_RESET  8'hDB
`define REC_STEP_CLKS     5'h04
`define MCLK_PERIOD_NS    4
`define MCLK_KHZ          250000
`define OSC_KHZ           14318
`define OSC_ISA_DIV       ((`MCLK_KHZ * 2) / `OSC_KHZ)
`define REFRESH_BASE_NS   15000
`define REFRESH_BASE_CYC  (`REFRESH_BASE_NS / `MCLK_PERIOD_NS)
`endif

// [verilog/isa_ctrl_pkg.sv]
// Types shared by the ISA recovery and speed control logic.
// Assumes the field layout of the two byte-wide control registers.
package isa_ctrl_pkg;
  typedef struct packed {
    logic       mouse_present;
    logic [1:0] refresh_sel;
    logic       coproc_mask;
    logic [2:0] rec_len;
    logic       rec_en;
  } rec_ctrl_s;

  typedef struct packed {
    logic prefetch_en;
    logic reserved6;
    logic a16_swap;
    logic sys_full;
    logic button_level;
    logic button_en;
    logic sw_full;
    logic equal_prio;
  } speed_ctrl_s;

  typedef enum logic [1:0] {
    REC_IDLE    = 2'h0,
    REC_BUSY    = 2'h1,
    REC_RECOVER = 2'h3
  } rec_state_e;
endpackage

// [verilog/isa_recovery_speed_control.sv]
// ISA I/O recovery, refresh period, interrupt masking and speed control block.
// Assumes APB master on mclk and synchronous ISA-side handshakes.
//
// Operation
// - Recovery enable bit set inserts an idle interval between I/O cycles.
// - Recovery length code selects four ISA clocks per step, 0 to 28.
// - Coprocessor error raises interrupt unless the mask bit is set.
// - Refresh field picks 15, 30, 60 or 120 microsecond period.
// - Mouse present latches interrupt 12 rising edge until keyboard read.
// - Priority 0: button high forces full speed, blocks software changes.
// - Priority 1: latest speed request from either source wins.
// - Software speed bit requests full or reduced speed.
// - Button pin ignored unless button enable bit is set.
// - Read-only bit 3 returns the button pin level.
// - Read-only bit 4 reports system speed, mirrored on indicator output.
// - Swap bit inverts A16 in E/F ROM accesses.
// - Prefetch bit enables ISA/DMA master read prefetch.
// - Speed register resets to DBh.
// - Recovery register at index 2Ah, resets to 00h, read/write.
// - ISA clock from oscillator halved or CPU clock divided.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "isa_ctrl_defs.svh"
module isa_recovery_speed_control
#(
  parameter int REFRESH_BASE_CYC = `REFRESH_BASE_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        isa_clk_osc_sel,
  input  wire logic [7:0]  cpu_clk_ratio,
  input  wire logic        io_cmd_req,
  input  wire logic        io_cmd_end,
  output logic             io_cmd_grant,
  input  wire logic        coproc_error_in_n,
  output logic             coproc_irq,
  input  wire logic        irq12_in,
  input  wire logic        kbc_read,
  output logic             irq12_out,
  output logic             refresh_req,
  input  wire logic        speed_button_in,
  output logic             speed_indicator_out,
  input  wire logic        cpu_a16,
  input  wire logic        rom_ef_access,
  output logic             isa_a16,
  output logic             prefetch_en
);
  isa_ctrl_pkg::rec_ctrl_s   rec_ctrl;
  isa_ctrl_pkg::rec_ctrl_s   next_rec_ctrl;
  isa_ctrl_pkg::speed_ctrl_s speed_ctrl;
  isa_ctrl_pkg::speed_ctrl_s next_speed_ctrl;
  isa_ctrl_pkg::rec_state_e  rec_state;
  isa_ctrl_pkg::rec_state_e  next_rec_state;
  logic [4:0]  rec_cnt;
  logic [4:0]  next_rec_cnt;
  logic [15:0] ref_cnt;
  logic [15:0] next_ref_cnt;
  logic        button_q;
  logic        irq12_q;
  logic        full_speed;
  logic        next_full_speed;
  logic        next_irq12_out;
  logic        next_grant;
  logic        next_refresh;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        isa_tick;
  logic [7:0]  isa_ratio;
  logic        acc;
  logic        wr_rec;
  logic        wr_speed;

  function automatic logic [4:0] rec_clocks(input logic [2:0] code);
    rec_clocks = `REC_STEP_CLKS * {2'h0, code};
  endfunction

  function automatic logic [15:0] refresh_cycles(input logic [1:0] sel);
    refresh_cycles = 16'(REFRESH_BASE_CYC) << sel;
  endfunction

  // Oscillator path is a fixed halving; CPU path uses the programmed factor
  assign isa_ratio = isa_clk_osc_sel ? 8'(`OSC_ISA_DIV) : cpu_clk_ratio;

  isa_clk_div u_isa_clk_div
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ratio (isa_ratio),
    .tick  (isa_tick)
  );

  // APB: one wait state, answer registered
  assign acc      = psel && penable && pready;
  assign wr_rec   = acc && pwrite && (paddr == `REC_CTRL_ADDR);
  assign wr_speed = acc && pwrite && (paddr == `SPEED_CTRL_ADDR);

  always_comb
  begin
    next_pready  = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (psel && penable && !pready)
    begin
      if (paddr == `REC_CTRL_ADDR)
        next_prdata = {24'h000000, rec_ctrl};
      else if (paddr == `SPEED_CTRL_ADDR)
        next_prdata = {24'h000000, speed_ctrl.prefetch_en, speed_ctrl.reserved6,
                       speed_ctrl.a16_swap, full_speed, button_q,
                       speed_ctrl.button_en, speed_ctrl.sw_full, speed_ctrl.equal_prio};
      else
        next_pslverr = 1'b1;
    end
  end

  always_comb
  begin
    next_rec_ctrl   = rec_ctrl;
    next_speed_ctrl = speed_ctrl;
    if (wr_rec)
      next_rec_ctrl = pwdata[7:0];
    if (wr_speed)
    begin
      // Status bits are not storage; reserved bit is kept as written
      next_speed_ctrl              = pwdata[7:0];
      next_speed_ctrl.sys_full     = 1'b0;
      next_speed_ctrl.button_level = 1'b0;
    end
  end

  // Speed arbitration
  always_comb
  begin
    next_full_speed = full_speed;
    if (!speed_ctrl.equal_prio)
    begin
      if (speed_ctrl.button_en && speed_button_in)
        next_full_speed = 1'b1;
      else if (wr_speed)
        next_full_speed = pwdata[1];
      else
        next_full_speed = speed_ctrl.sw_full;
    end
    else
    begin
      // Button edge and software write in one cycle: the write is later in effect
      if (speed_ctrl.button_en && (speed_button_in != button_q))
        next_full_speed = speed_button_in;
      if (wr_speed)
        next_full_speed = pwdata[1];
    end
  end

  // Recovery sequencer
  always_comb
  begin
    next_rec_state = rec_state;
    next_rec_cnt   = rec_cnt;
    next_grant     = 1'b0;
    unique case (rec_state)
      isa_ctrl_pkg::REC_IDLE:
        if (io_cmd_req && !io_cmd_grant)
        begin
          next_grant     = 1'b1;
          next_rec_state = isa_ctrl_pkg::REC_BUSY;
        end
      isa_ctrl_pkg::REC_BUSY:
        if (io_cmd_end)
        begin
          if (rec_ctrl.rec_en && (rec_ctrl.rec_len != 3'h0))
          begin
            next_rec_cnt   = rec_clocks(rec_ctrl.rec_len);
            next_rec_state = isa_ctrl_pkg::REC_RECOVER;
          end
          else
            next_rec_state = isa_ctrl_pkg::REC_IDLE;
        end
      isa_ctrl_pkg::REC_RECOVER:
        if (isa_tick)
        begin
          next_rec_cnt = rec_cnt - 5'h01;
          if (rec_cnt == 5'h01)
            next_rec_state = isa_ctrl_pkg::REC_IDLE;
        end
      default:
        next_rec_state = isa_ctrl_pkg::REC_IDLE;
    endcase
  end

  // Refresh timer and interrupt conditioning
  always_comb
  begin
    next_refresh = 1'b0;
    next_ref_cnt = ref_cnt - 16'h0001;
    if (ref_cnt == 16'h0000)
    begin
      next_ref_cnt = refresh_cycles(rec_ctrl.refresh_sel) - 16'h0001;
      next_refresh = 1'b1;
    end
    next_irq12_out = irq12_in;
    if (rec_ctrl.mouse_present)
      next_irq12_out = (irq12_in && !irq12_q) || (irq12_out && !kbc_read);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      rec_ctrl            <= `REC_CTRL_RESET;
      speed_ctrl          <= `SPEED_CTRL_RESET;
      full_speed          <= 1'b1;
      speed_indicator_out <= 1'b1;
      button_q            <= 1'b0;
      irq12_q             <= 1'b0;
      irq12_out           <= 1'b0;
      coproc_irq          <= 1'b0;
      rec_state           <= isa_ctrl_pkg::REC_IDLE;
      rec_cnt             <= 5'h00;
      io_cmd_grant        <= 1'b0;
      ref_cnt             <= 16'h0000;
      refresh_req         <= 1'b0;
      isa_a16             <= 1'b0;
      prefetch_en         <= 1'b1;
    end
    else
    begin
      prdata              <= next_prdata;
      pready              <= next_pready;
      pslverr             <= next_pslverr;
      rec_ctrl            <= next_rec_ctrl;
      speed_ctrl          <= next_speed_ctrl;
      full_speed          <= next_full_speed;
      speed_indicator_out <= next_full_speed;
      button_q            <= speed_button_in;
      irq12_q             <= irq12_in;
      irq12_out           <= next_irq12_out;
      coproc_irq          <= !coproc_error_in_n && !rec_ctrl.coproc_mask;
      rec_state           <= next_rec_state;
      rec_cnt             <= next_rec_cnt;
      io_cmd_grant        <= next_grant;
      ref_cnt             <= next_ref_cnt;
      refresh_req         <= next_refresh;
      isa_a16             <= cpu_a16 ^ (speed_ctrl.a16_swap && rom_ef_access);
      prefetch_en         <= speed_ctrl.prefetch_en;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_rec_hold_off: assert property (
    rec_state == isa_ctrl_pkg::REC_RECOVER |=> !io_cmd_grant)
    else $error("grant during recovery");

  a_rec_length: assert property (
    (rec_state == isa_ctrl_pkg::REC_BUSY) && io_cmd_end && rec_ctrl.rec_en
      |=> rec_cnt == 5'(4 * $past(rec_ctrl.rec_len)))
    else $error("recovery length wrong");

  a_rec_disabled: assert property (
    (rec_state == isa_ctrl_pkg::REC_BUSY) && io_cmd_end && !rec_ctrl.rec_en
      |=> rec_state == isa_ctrl_pkg::REC_IDLE)
    else $error("recovery inserted while disabled");

  a_coproc_mask: assert property (
    rec_ctrl.coproc_mask && $stable(rec_ctrl) ##1 rec_ctrl.coproc_mask |-> !coproc_irq)
    else $error("masked coprocessor error raised");

  a_irq12_latch: assert property (
    rec_ctrl.mouse_present && irq12_in && !irq12_q
      ##1 (rec_ctrl.mouse_present && !kbc_read)[*2] |-> irq12_out[*2])
    else $error("mouse interrupt not held");

  a_hw_priority: assert property (
    !speed_ctrl.equal_prio && speed_ctrl.button_en && speed_button_in
      |=> full_speed && speed_indicator_out)
    else $error("button did not force full speed");

  a_button_ignored: assert property (
    speed_ctrl.equal_prio && !speed_ctrl.button_en && !wr_speed |=> $stable(full_speed))
    else $error("disabled button changed speed");

  a_a16_swap: assert property (
    speed_ctrl.a16_swap && rom_ef_access |=> isa_a16 != $past(cpu_a16))
    else $error("A16 not swapped");

  a_refresh_gap: assert property (
    refresh_req |=> !refresh_req[*8])
    else $error("refresh pulses too close");

  c_recovery_run: cover property (
    rec_state == isa_ctrl_pkg::REC_BUSY ##1 rec_state == isa_ctrl_pkg::REC_RECOVER);
  c_sw_deturbo: cover property (wr_speed && !pwdata[1] ##1 !full_speed);
  c_mouse_latch: cover property (rec_ctrl.mouse_present && irq12_out && kbc_read);
  c_refresh: cover property (refresh_req);
endmodule
